// file: dv/kesc_host.sv
// host cpu model issuing single io port cycles
`timescale 1ns/1ps
`default_nettype none
module kesc_host (
  input wire logic clk,
  output logic [15:0] io_addr,
  output logic io_wr,
  output logic io_rd,
  output logic [7:0] io_wdata,
  input wire logic [7:0] io_rdata,
  input wire logic io_ack
);
  // idle bus at time zero
  initial begin
    io_addr = 16'hffff;
    io_wr = 1'b0;
    io_rd = 1'b0;
    io_wdata = 8'h00;
  end

  // one-cycle strobe, address held until ack or three cycles, answer taken at the ack edge
  task automatic cyc(input logic w, input logic [15:0] a, input logic [7:0] d,
      output logic [7:0] q, output logic ak);
    int n;
    q = 8'hff;
    ak = 1'b0;
    @(posedge clk);
    io_addr <= a;
    io_wdata <= d;
    io_wr <= w;
    io_rd <= ~w;
    @(posedge clk);
    io_wr <= 1'b0;
    io_rd <= 1'b0;
    for (n = 0; n < 3 && ak !== 1'b1; n++) begin
      @(posedge clk);
      ak = io_ack;
      q = io_rdata;
    end
    // released lines stop showing the last value
    io_addr <= ~a;
    io_wdata <= ~d;
  endtask
endmodule
`default_nettype wire

// file: dv/test_kesc_top.sv
// self-checking bench for the keyboard emulation and system control block
`timescale 1ns/1ps
`default_nettype none
module test_kesc_top;
  logic clk;
  logic rst = 1'b1;
  logic [15:0] io_addr;
  logic io_wr, io_rd, io_ack, halt_cycle, parity_error, refresh_cycle, chk_n, tmr, rdy_n;
  logic [7:0] io_wdata, io_rdata, q, d;
  logic gate, wrst, tgate, spk, nmi, bclk, slow, hid, swap, ale, xws, pdis, crdy_n, rdone;
  logic ak;
  logic [2:0] rec;
  int n_fail = 0;
  int check_count = 0;
  int n, r;

  // -------------------------------------------------------------
  // clock, design and host
  // -------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  kesc_top dut_u (.clk(clk), .rst(rst), .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd),
    .io_wdata(io_wdata), .io_rdata(io_rdata), .io_ack(io_ack), .halt_cycle(halt_cycle),
    .parity_error(parity_error), .refresh_cycle(refresh_cycle),
    .channel_check_input_n(chk_n), .timer_ch2_output(tmr), .local_ready_input_n(rdy_n),
    .fast_address_line_gate(gate), .cpu_warm_reset_pulse(wrst), .timer_ch2_gate(tgate),
    .speaker_output(spk), .nmi(nmi), .expansion_bus_clock(bclk), .io_recovery_clocks(rec),
    .slow_refresh_en(slow), .hidden_refresh_en(hid), .bus_master_byte_swap_en(swap),
    .multi_ale_en(ale), .extra_wait_state_en(xws), .parity_check_disable(pdis),
    .cpu_ready_n(crdy_n), .local_ready_done(rdone));

  kesc_host host_u (.clk(clk), .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd),
    .io_wdata(io_wdata), .io_rdata(io_rdata), .io_ack(io_ack));

  // -------------------------------------------------------------
  // helpers
  // -------------------------------------------------------------
  function automatic int exp_rec(input int c);
    return 3 + c;
  endfunction

  function automatic int exp_half(input int c);
    return (10 - 2 * c) / 2;
  endfunction

  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    check_count++;
    if (s !== e) begin
      n_fail++;
      $display("[ERR] %0t seen %h expected %h", $time, s, e);
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] v);
    host_u.cyc(1'b1, a, v, q, ak);
  endtask

  task automatic rd(input logic [15:0] a);
    host_u.cyc(1'b0, a, 8'h00, q, ak);
  endtask

  // fresh index before every data access
  task automatic cfg_wr(input logic [7:0] i, input logic [7:0] v);
    wr(16'h0022, i);
    wr(16'h0024, v);
  endtask

  task automatic cfg_rd(input logic [7:0] i);
    wr(16'h0022, i);
    rd(16'h0024);
  endtask

  // cycles between two toggles of the bus clock
  task automatic halfp(output int c);
    logic b;
    for (int k = 0; k < 2; k++) begin
      b = bclk;
      c = 0;
      while (bclk === b && c < 40) begin
        @(posedge clk);
        c++;
      end
    end
  endtask

  // cycles for which the warm reset pulse stays high
  task automatic hi_len(output int c);
    c = 0;
    while (wrst === 1'b1 && c < 40) begin
      c++;
      @(posedge clk);
    end
  endtask

  task automatic results;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // watchdog against a hung handshake
  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    results();
  end

  // -------------------------------------------------------------
  // tests
  // -------------------------------------------------------------
  initial begin
    halt_cycle = 1'b0;
    parity_error = 1'b0;
    refresh_cycle = 1'b0;
    chk_n = 1'b1;
    tmr = 1'b0;
    rdy_n = 1'b1;
    r = $urandom(84720);
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    cfg_rd(8'h20);
    chk(q, 8'h00);
    cfg_rd(8'h21);
    chk(q, 8'h40);
    rd(16'h0024);
    chk(q, 8'hff);
    rd(16'h0061);
    chk(q, 8'h00);
    chk({7'h00, ak}, 8'h01);
    chk({4'h0, ale, rec}, 8'h0b);
    rd(16'h0070);
    chk({7'h00, ak}, 8'h00);
    $display("test reset done");
    for (int i = 0; i < 4; i++) begin
      d = 8'($urandom);
      d[5:4] = 2'(i);
      d[1:0] = 2'(i);
      cfg_wr(8'h20, d);
      @(posedge clk); // recovery count settles one cycle after the field
      chk({5'h00, rec}, 8'(exp_rec(i)));
      chk({6'h00, slow, hid}, {6'h00, d[3:2]});
      cfg_rd(8'h20);
      chk(q, {2'h0, d[5:0]});
      halfp(n);
      chk(8'(n), 8'(exp_half(i)));
    end
    d = 8'($urandom);
    for (int i = 0; i < 2; i++) begin
      d[5] = 1'b0;
      d[3:2] = 2'h0;
      cfg_wr(8'h21, d);
      chk({4'h0, swap, ale, xws, pdis}, {4'h0, d[7:6], d[4], d[0]});
      cfg_rd(8'h21);
      chk(q, d);
      d = ~d;
    end
    $display("test config done");
    wr(16'h0064, 8'hd1);
    wr(16'h0060, 8'h02);
    chk({7'h00, gate}, 8'h01);
    wr(16'h0064, 8'hd0);
    rd(16'h0060);
    chk(q, 8'h02);
    wr(16'h0064, 8'hd1);
    wr(16'h0060, 8'h00);
    chk({7'h00, gate}, 8'h00);
    cfg_wr(8'h21, 8'h60);
    wr(16'h0064, 8'hfe);
    hi_len(n);
    chk(8'(n), 8'h10);
    wr(16'h0064, 8'hfe);
    wr(16'h0064, 8'hd0);
    rd(16'h0060);
    chk(q, 8'h01);
    hi_len(n);
    chk(8'(n), 8'h0a);
    cfg_wr(8'h21, 8'h40);
    wr(16'h0064, 8'hfe);
    repeat (6) @(posedge clk);
    chk({7'h00, wrst}, 8'h00);
    halt_cycle <= 1'b1;
    @(posedge clk);
    halt_cycle <= 1'b0;
    @(posedge clk);
    hi_len(n);
    chk(8'(n), 8'h10);
    $display("test keyboard done");
    tmr <= 1'b1;
    wr(16'h0061, 8'h03);
    repeat (4) @(posedge clk);
    chk({6'h00, spk, tgate}, 8'h03);
    rd(16'h0061);
    chk(q, 8'h23);
    tmr <= 1'b0;
    repeat (4) @(posedge clk);
    chk({7'h00, spk}, 8'h00);
    wr(16'h0061, 8'h01);
    tmr <= 1'b1;
    repeat (4) @(posedge clk);
    chk({7'h00, spk}, 8'h00);
    refresh_cycle <= 1'b1;
    @(posedge clk);
    refresh_cycle <= 1'b0;
    rd(16'h0061);
    chk(q, 8'h31);
    wr(16'h0061, 8'h00);
    for (int m = 0; m < 2; m++) begin
      parity_error <= 1'b1;
      @(posedge clk);
      parity_error <= 1'b0;
      repeat (3) @(posedge clk);
      chk({7'h00, nmi}, 8'(1 - m));
      rd(16'h0061);
      chk(q, m == 0 ? 8'hb0 : 8'h34);
      wr(16'h0061, 8'h04);
    end
    wr(16'h0061, 8'h00);
    for (int m = 0; m < 2; m++) begin
      chk_n <= 1'b0;
      repeat (5) @(posedge clk);
      chk({7'h00, nmi}, 8'(1 - m));
      chk_n <= 1'b1;
      repeat (3) @(posedge clk);
      rd(16'h0061);
      chk(q, m == 0 ? 8'h70 : 8'h38);
      wr(16'h0061, 8'h08);
    end
    wr(16'h0061, 8'h00);
    $display("test port b done");
    cfg_wr(8'h21, 8'h40);
    rdy_n <= 1'b0;
    repeat (3) @(posedge clk);
    chk({7'h00, crdy_n}, 8'h01);
    @(posedge clk);
    chk({7'h00, crdy_n}, 8'h00);
    rdy_n <= 1'b1;
    cfg_wr(8'h21, 8'h42);
    rdy_n <= 1'b0; // local device ready reaches only the done output, cpu ready held off
    repeat (4) @(posedge clk);
    chk({6'h00, crdy_n, rdone}, 8'h03);
    rdy_n <= 1'b1;
    $display("test ready done");
    results();
  end
endmodule
`default_nettype wire

// file: logic/kesc_pkg.sv
// constants, types and helpers for the keyboard emulation and system control block
//
// Function
// - D1h then 02h sets fast gate
// - FEh on 64h makes fast warm reset
// - after D0h, 60h read shows gate, reset
// - parity flag sets only unmasked, bit2 clears
// - channel flag sets only unmasked, bit3 clears
// - bit5 reads live timer output level
// - bit4 toggles once per refresh cycle
// - low channel check raises NMI unless masked
// - parity error raises NMI unless masked
// - speaker is timer output AND bit1
// - bit0 drives timer gate directly
// - recovery code gives 3 to 6 clocks
// - bus clock divides by 10,8,6,4
// - 21h bit7 enables master byte swap
// - 21h bit6 selects multiple latch pulses
// - 21h bit5 chooses halt wait or immediate
// - 21h bit4 adds one wait state
// - 21h bit1 holds cpu ready off, leaving only local ready done
// - 21h bit0 high disables parity checking
// - index write then one data access
`default_nettype none
package kesc_pkg;
  // ---------------------------------------------------------------
  // io port map
  // ---------------------------------------------------------------
  localparam logic [15:0] PORT_KBD_DATA = 16'h0060;
  localparam logic [15:0] PORT_SYS_B = 16'h0061;
  localparam logic [15:0] PORT_KBD_CMD = 16'h0064;
  localparam logic [15:0] PORT_CFG_INDEX = 16'h0022;
  localparam logic [15:0] PORT_CFG_DATA = 16'h0024;
  localparam logic [7:0] IDX_REV_BUS = 8'h20;
  localparam logic [7:0] IDX_SYS_CTRL = 8'h21;

  // ---------------------------------------------------------------
  // keyboard emulation commands
  // ---------------------------------------------------------------
  localparam logic [7:0] CMD_WRITE_OUTPUT = 8'hd1;
  localparam logic [7:0] CMD_READ_OUTPUT = 8'hd0;
  localparam logic [7:0] CMD_WARM_RESET = 8'hfe;
  localparam logic [7:0] DATA_GATE_ON = 8'h02;
  localparam int GATE_BIT = 1;
  localparam logic [7:0] READ_IDLE = 8'hff;

  // ---------------------------------------------------------------
  // port b field positions
  // ---------------------------------------------------------------
  localparam int PB_PAR_FLAG = 7;
  localparam int PB_CHK_FLAG = 6;
  localparam int PB_TIMER_CH2_OUTPUT = 5;
  localparam int PB_RFSH = 4;
  localparam int PB_CHK_DIS = 3;
  localparam int PB_PAR_DIS = 2;
  localparam int PB_SPK_EN = 1;
  localparam int PB_TIMER_CH2_GATE = 0;
  localparam logic [3:0] PORTB_RESET = 4'h0;

  // ---------------------------------------------------------------
  // configuration field positions and reset values
  // ---------------------------------------------------------------
  localparam int C20_REC_HI = 5;
  localparam int C20_REC_LO = 4;
  localparam int C20_SLOW = 3;
  localparam int C20_HIDDEN = 2;
  localparam int C20_CLK_HI = 1;
  localparam int C20_CLK_LO = 0;
  localparam int C21_SWAP = 7;
  localparam int C21_ALE = 6;
  localparam int C21_RST_DIRECT = 5;
  localparam int C21_WAIT = 4;
  localparam int C21_READY_BYP = 1;
  localparam int C21_PAR_DIS = 0;
  localparam logic [5:0] CFG20_RESET = 6'h00;
  localparam logic [7:0] CFG21_RESET = 8'h40;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam logic [2:0] REC_BASE_CLOCKS = 3'h3;
  localparam logic [3:0] DIV_RATIO_0 = 4'ha;
  localparam logic [3:0] DIV_RATIO_1 = 4'h8;
  localparam logic [3:0] DIV_RATIO_2 = 4'h6;
  localparam logic [3:0] DIV_RATIO_3 = 4'h4;
  localparam int CLK_PERIOD_NS = 8;
  localparam int RESET_PULSE_NS = 128;
  localparam int RESET_PULSE_CYCLES = (RESET_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [4:0] RESET_PULSE_LOAD = 5'(RESET_PULSE_CYCLES - 1);
  localparam logic [2:0] SYNC_RESET = 3'h5;

  // ---------------------------------------------------------------
  // state encodings
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {KBD_IDLE, KBD_WAIT_DATA, KBD_STATUS} kesc_kbd_t;
  typedef enum logic [1:0] {RST_IDLE, RST_WAIT_HALT, RST_PULSE} kesc_rst_t;

  // address compare used by every port decode
  function automatic logic is_port(input logic [15:0] addr, input logic [15:0] port);
    return addr == port;
  endfunction

  // half period of the bus clock in fast clocks for a divider code
  function automatic logic [2:0] half_period(input logic [1:0] sel);
    logic [3:0] ratio;
    ratio = DIV_RATIO_0;
    case (sel)
      2'h0: ratio = DIV_RATIO_0;
      2'h1: ratio = DIV_RATIO_1;
      2'h2: ratio = DIV_RATIO_2;
      default: ratio = DIV_RATIO_3;
    endcase
    return ratio[3:1];
  endfunction
endpackage
`default_nettype wire

// file: logic/kesc_sync.sv
// two-flop synchronizer for the three asynchronous pin inputs
`timescale 1ns/1ps
`default_nettype none
module kesc_sync (
  input wire logic clk,
  input wire logic rst,
  input wire logic [2:0] pin_in,
  output logic [2:0] pin_sync
);
  typedef struct packed {
    logic [2:0] stage1;
    logic [2:0] stage2;
  } kesc_sync_t;

  kesc_sync_t state_reg;
  kesc_sync_t state_next;

  // ---------------------------------------------------------------
  // first stage feeds only the second stage
  // ---------------------------------------------------------------
  always_comb begin
    state_next.stage1 = pin_in;
    state_next.stage2 = state_reg.stage1;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg <= {kesc_pkg::SYNC_RESET, kesc_pkg::SYNC_RESET};
    end else begin
      state_reg <= state_next;
    end
  end

  assign pin_sync = state_reg.stage2;
endmodule
`default_nettype wire

// file: logic/kesc_top.sv
// keyboard emulation, port b and indexed system configuration registers
`timescale 1ns/1ps
`default_nettype none
module kesc_top #(
  parameter logic [1:0] REVISION = 2'h0 // arbitrary value
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [15:0] io_addr,
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic [7:0] io_wdata,
  output logic [7:0] io_rdata,
  output logic io_ack,
  input wire logic halt_cycle,
  input wire logic parity_error,
  input wire logic refresh_cycle,
  input wire logic channel_check_input_n,
  input wire logic timer_ch2_output,
  input wire logic local_ready_input_n,
  output logic fast_address_line_gate,
  output logic cpu_warm_reset_pulse,
  output logic timer_ch2_gate,
  output logic speaker_output,
  output logic nmi,
  output logic expansion_bus_clock,
  output logic [2:0] io_recovery_clocks,
  output logic slow_refresh_en,
  output logic hidden_refresh_en,
  output logic bus_master_byte_swap_en,
  output logic multi_ale_en,
  output logic extra_wait_state_en,
  output logic parity_check_disable,
  output logic cpu_ready_n,
  output logic local_ready_done
);
  typedef struct packed {
    kesc_pkg::kesc_kbd_t kbd;
    kesc_pkg::kesc_rst_t rst_st;
    logic [4:0] rst_cnt;
    logic rst_out;
    logic gate;
    logic [3:0] pb;
    logic par_flag;
    logic chk_flag;
    logic rfsh_tog;
    logic speaker;
    logic nmi;
    logic [7:0] idx;
    logic idx_valid;
    logic [5:0] cfg20;
    logic [7:0] cfg21;
    logic [2:0] div_cnt;
    logic bus_clk;
    logic [2:0] rec_clocks;
    logic ready_n;
    logic ready_done;
    logic [7:0] rdata;
    logic ack;
  } kesc_state_t;

  kesc_state_t q;
  kesc_state_t d;
  logic [2:0] pin_sync;
  logic chk_low;
  logic timer_ch2_output_live;
  logic ready_sync_n;
  logic wr_data;
  logic wr_portb;
  logic wr_cmd;
  logic wr_index;
  logic wr_cfg;
  logic rd_data;
  logic rd_portb;
  logic rd_cfg;
  logic mapped;
  logic par_set;
  logic chk_set;

  // ---------------------------------------------------------------
  // pin synchronizers
  // ---------------------------------------------------------------
  kesc_sync u_sync (
    .clk(clk),
    .rst(rst),
    .pin_in({local_ready_input_n, timer_ch2_output, channel_check_input_n}),
    .pin_sync(pin_sync)
  );

  // split synchronized pins
  assign chk_low = ~pin_sync[0];
  assign timer_ch2_output_live = pin_sync[1];
  assign ready_sync_n = pin_sync[2];

  // ---------------------------------------------------------------
  // port decode
  // ---------------------------------------------------------------
  assign wr_data = io_wr & kesc_pkg::is_port(io_addr, kesc_pkg::PORT_KBD_DATA);
  assign wr_portb = io_wr & kesc_pkg::is_port(io_addr, kesc_pkg::PORT_SYS_B);
  assign wr_cmd = io_wr & kesc_pkg::is_port(io_addr, kesc_pkg::PORT_KBD_CMD);
  assign wr_index = io_wr & kesc_pkg::is_port(io_addr, kesc_pkg::PORT_CFG_INDEX);
  assign wr_cfg = io_wr & kesc_pkg::is_port(io_addr, kesc_pkg::PORT_CFG_DATA);
  assign rd_data = io_rd & kesc_pkg::is_port(io_addr, kesc_pkg::PORT_KBD_DATA);
  assign rd_portb = io_rd & kesc_pkg::is_port(io_addr, kesc_pkg::PORT_SYS_B);
  assign rd_cfg = io_rd & kesc_pkg::is_port(io_addr, kesc_pkg::PORT_CFG_DATA);
  assign mapped = (io_wr | io_rd) & (kesc_pkg::is_port(io_addr, kesc_pkg::PORT_KBD_DATA)
    | kesc_pkg::is_port(io_addr, kesc_pkg::PORT_SYS_B)
    | kesc_pkg::is_port(io_addr, kesc_pkg::PORT_KBD_CMD)
    | kesc_pkg::is_port(io_addr, kesc_pkg::PORT_CFG_INDEX)
    | kesc_pkg::is_port(io_addr, kesc_pkg::PORT_CFG_DATA));

  // error flag set terms, judged on the masks held before this cycle
  assign par_set = parity_error & ~q.pb[kesc_pkg::PB_PAR_DIS]
    & ~q.cfg21[kesc_pkg::C21_PAR_DIS];
  assign chk_set = chk_low & ~q.pb[kesc_pkg::PB_CHK_DIS];

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    d = q;
    d.ack = mapped;
    d.rdata = kesc_pkg::READ_IDLE;

    // keyboard command decode
    if (wr_cmd) begin
      case (io_wdata)
        kesc_pkg::CMD_WRITE_OUTPUT: d.kbd = kesc_pkg::KBD_WAIT_DATA;
        kesc_pkg::CMD_READ_OUTPUT: d.kbd = kesc_pkg::KBD_STATUS;
        default: d.kbd = kesc_pkg::KBD_IDLE;
      endcase
      if (io_wdata == kesc_pkg::CMD_WARM_RESET && q.rst_st == kesc_pkg::RST_IDLE) begin
        if (q.cfg21[kesc_pkg::C21_RST_DIRECT]) begin
          d.rst_st = kesc_pkg::RST_PULSE;
          d.rst_cnt = kesc_pkg::RESET_PULSE_LOAD;
        end else begin
          d.rst_st = kesc_pkg::RST_WAIT_HALT;
        end
      end
    end

    // data phase of the write-output command
    if (wr_data && q.kbd == kesc_pkg::KBD_WAIT_DATA) begin
      d.gate = io_wdata[kesc_pkg::GATE_BIT];
      d.kbd = kesc_pkg::KBD_IDLE;
    end

    // status readback of gate and reset
    if (rd_data && q.kbd == kesc_pkg::KBD_STATUS) begin
      d.rdata = {6'h00, q.gate, q.rst_st == kesc_pkg::RST_PULSE};
      d.kbd = kesc_pkg::KBD_IDLE;
    end

    // warm reset sequencing
    case (q.rst_st)
      kesc_pkg::RST_WAIT_HALT: begin
        if (halt_cycle) begin
          d.rst_st = kesc_pkg::RST_PULSE;
          d.rst_cnt = kesc_pkg::RESET_PULSE_LOAD;
        end
      end
      kesc_pkg::RST_PULSE: begin
        if (q.rst_cnt == 5'h00) begin
          d.rst_st = kesc_pkg::RST_IDLE;
        end else begin
          d.rst_cnt = q.rst_cnt - 5'h01;
        end
      end
      default: begin
      end
    endcase

    // port b control bits and error flags, set wins over clear
    if (wr_portb) begin
      d.pb = io_wdata[kesc_pkg::PB_CHK_DIS:kesc_pkg::PB_TIMER_CH2_GATE];
    end
    d.par_flag = par_set | (q.par_flag & ~(wr_portb & io_wdata[kesc_pkg::PB_PAR_DIS]));
    d.chk_flag = chk_set | (q.chk_flag & ~(wr_portb & io_wdata[kesc_pkg::PB_CHK_DIS]));
    if (refresh_cycle) begin
      d.rfsh_tog = ~q.rfsh_tog;
    end
    if (rd_portb) begin
      d.rdata = {q.par_flag, q.chk_flag, timer_ch2_output_live, q.rfsh_tog, q.pb};
    end

    // nmi from unmasked error sources
    d.nmi = (q.par_flag & ~q.pb[kesc_pkg::PB_PAR_DIS])
      | (q.chk_flag & ~q.pb[kesc_pkg::PB_CHK_DIS]);
    d.speaker = timer_ch2_output_live & q.pb[kesc_pkg::PB_SPK_EN];

    // indexed configuration access, index spent by each data access
    if (wr_index) begin
      d.idx = io_wdata;
      d.idx_valid = 1'b1;
    end
    if (wr_cfg || rd_cfg) begin
      d.idx_valid = 1'b0;
    end
    if (wr_cfg && q.idx_valid) begin
      if (q.idx == kesc_pkg::IDX_REV_BUS) begin
        d.cfg20 = io_wdata[kesc_pkg::C20_REC_HI:kesc_pkg::C20_CLK_LO];
      end
      if (q.idx == kesc_pkg::IDX_SYS_CTRL) begin
        d.cfg21 = io_wdata;
      end
    end
    if (rd_cfg && q.idx_valid) begin
      if (q.idx == kesc_pkg::IDX_REV_BUS) begin
        d.rdata = {REVISION, q.cfg20};
      end
      if (q.idx == kesc_pkg::IDX_SYS_CTRL) begin
        d.rdata = q.cfg21;
      end
    end

    // expansion bus clock divider
    if (q.div_cnt == 3'h0) begin
      d.bus_clk = ~q.bus_clk;
      d.div_cnt = kesc_pkg::half_period(q.cfg20[kesc_pkg::C20_CLK_HI:kesc_pkg::C20_CLK_LO])
        - 3'h1;
    end else begin
      d.div_cnt = q.div_cnt - 3'h1;
    end
    d.rec_clocks = kesc_pkg::REC_BASE_CLOCKS
      + {1'b0, q.cfg20[kesc_pkg::C20_REC_HI:kesc_pkg::C20_REC_LO]};

    // local ready: synchronized path or bypass
    d.ready_n = q.cfg21[kesc_pkg::C21_READY_BYP] | ready_sync_n;
    d.ready_done = ~ready_sync_n;
    d.rst_out = (d.rst_st == kesc_pkg::RST_PULSE);
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      q.kbd <= kesc_pkg::KBD_IDLE;
      q.rst_st <= kesc_pkg::RST_IDLE;
      q.rst_cnt <= 5'h00;
      q.rst_out <= 1'b0;
      q.gate <= 1'b0;
      q.pb <= kesc_pkg::PORTB_RESET;
      q.par_flag <= 1'b0;
      q.chk_flag <= 1'b0;
      q.rfsh_tog <= 1'b0;
      q.speaker <= 1'b0;
      q.nmi <= 1'b0;
      q.idx <= 8'h00;
      q.idx_valid <= 1'b0;
      q.cfg20 <= kesc_pkg::CFG20_RESET;
      q.cfg21 <= kesc_pkg::CFG21_RESET;
      q.div_cnt <= 3'h0;
      q.bus_clk <= 1'b0;
      q.rec_clocks <= kesc_pkg::REC_BASE_CLOCKS;
      q.ready_n <= 1'b1;
      q.ready_done <= 1'b0;
      q.rdata <= kesc_pkg::READ_IDLE;
      q.ack <= 1'b0;
    end else begin
      q <= d;
    end
  end

  // ---------------------------------------------------------------
  // outputs straight from state flops
  // ---------------------------------------------------------------
  assign io_rdata = q.rdata;
  assign io_ack = q.ack;
  assign fast_address_line_gate = q.gate;
  assign cpu_warm_reset_pulse = q.rst_out;
  assign timer_ch2_gate = q.pb[kesc_pkg::PB_TIMER_CH2_GATE];
  assign speaker_output = q.speaker;
  assign nmi = q.nmi;
  assign expansion_bus_clock = q.bus_clk;
  assign io_recovery_clocks = q.rec_clocks;
  assign slow_refresh_en = q.cfg20[kesc_pkg::C20_SLOW];
  assign hidden_refresh_en = q.cfg20[kesc_pkg::C20_HIDDEN];
  assign bus_master_byte_swap_en = q.cfg21[kesc_pkg::C21_SWAP];
  assign multi_ale_en = q.cfg21[kesc_pkg::C21_ALE];
  assign extra_wait_state_en = q.cfg21[kesc_pkg::C21_WAIT];
  assign parity_check_disable = q.cfg21[kesc_pkg::C21_PAR_DIS];
  assign cpu_ready_n = q.ready_n;
  assign local_ready_done = q.ready_done;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  gate_set_a: assert property (wr_data && q.kbd == kesc_pkg::KBD_WAIT_DATA
    && io_wdata == kesc_pkg::DATA_GATE_ON |=> fast_address_line_gate)
    else $error("fast gate not set after write-output data");
  warm_direct_a: assert property (wr_cmd && io_wdata == kesc_pkg::CMD_WARM_RESET
    && q.cfg21[kesc_pkg::C21_RST_DIRECT] && q.rst_st == kesc_pkg::RST_IDLE
    |=> cpu_warm_reset_pulse)
    else $error("direct warm reset did not start");
  warm_halt_a: assert property (wr_cmd && io_wdata == kesc_pkg::CMD_WARM_RESET
    && !q.cfg21[kesc_pkg::C21_RST_DIRECT] && q.rst_st == kesc_pkg::RST_IDLE && !halt_cycle
    |=> !cpu_warm_reset_pulse ##1 (!cpu_warm_reset_pulse || $past(halt_cycle)))
    else $error("warm reset started without halt");
  pulse_width_a: assert property ($rose(cpu_warm_reset_pulse)
    |-> ##15 cpu_warm_reset_pulse ##1 !cpu_warm_reset_pulse)
    else $error("warm reset pulse width wrong");
  status_read_a: assert property (rd_data && q.kbd == kesc_pkg::KBD_STATUS
    |=> io_ack && io_rdata[1] == $past(fast_address_line_gate))
    else $error("status readback wrong");
  par_clear_a: assert property (wr_portb && io_wdata[kesc_pkg::PB_PAR_DIS] && !par_set
    |=> !q.par_flag ##1 !q.par_flag)
    else $error("parity flag not cleared");
  chk_mask_a: assert property (q.pb[kesc_pkg::PB_CHK_DIS] && !q.chk_flag
    && !(wr_portb && !io_wdata[kesc_pkg::PB_CHK_DIS]) |=> !q.chk_flag)
    else $error("channel flag set while masked");
  nmi_mask_a: assert property (q.pb[kesc_pkg::PB_CHK_DIS] && q.pb[kesc_pkg::PB_PAR_DIS]
    |=> !nmi)
    else $error("nmi raised while both sources masked");
  nmi_raise_a: assert property (q.chk_flag && !q.pb[kesc_pkg::PB_CHK_DIS] |=> nmi)
    else $error("channel check did not raise nmi");
  speaker_gate_a: assert property (speaker_output |-> $past(q.pb[kesc_pkg::PB_SPK_EN]))
    else $error("speaker active while disabled");
  index_spent_a: assert property ((wr_cfg || rd_cfg) |=> !q.idx_valid)
    else $error("index survived a data access");
  ready_bypass_a: assert property (q.cfg21[kesc_pkg::C21_READY_BYP] |=> cpu_ready_n)
    else $error("cpu ready driven in bypass mode");

  gate_set_c: cover property (!fast_address_line_gate ##1 fast_address_line_gate);
  warm_reset_c: cover property (q.rst_st == kesc_pkg::RST_WAIT_HALT ##[1:20] cpu_warm_reset_pulse);
  status_read_c: cover property (rd_data && q.kbd == kesc_pkg::KBD_STATUS);
  nmi_c: cover property ($rose(nmi));
endmodule
`default_nettype wire
